// ===== core/clock_gate_defs.vh
`ifndef CLOCK_GATE_DEFS_VH
`define CLOCK_GATE_DEFS_VH

// ****************************************************************
// Register map
// ****************************************************************
`define CG_ADDR_W              16
`define CG_DATA_W              8
`define CG_TIMER_GATE_ADDR     16'h0F74
`define CG_SERIAL_GATE_ADDR    16'h0F75
`define CG_RTC_SIO_GATE_ADDR   16'h0F76
`define CG_EXT_IRQ_GATE_ADDR   16'h0F77
`define CG_REG_RESET           8'h00
`define CG_READ_IDLE           8'h00

// ****************************************************************
// Field positions
// ****************************************************************
`define CG_TIMER_PAIR_2_3_BIT  5
`define CG_TIMER_PAIR_0_1_BIT  4
`define CG_TIMER_CHAN_A1_BIT   1
`define CG_TIMER_CHAN_A0_BIT   0
`define CG_I2C_UNIT_BIT        4
`define CG_UART_CH1_BIT        1
`define CG_UART_CH0_BIT        0
`define CG_REALTIME_CLOCK_BIT  5
`define CG_SERIAL_IO_CH0_BIT   0
`define CG_EXT_IRQ5_BIT        5
`define CG_EXT_IRQ4_BIT        4
`define CG_EXT_IRQ3_BIT        3
`define CG_EXT_IRQ2_BIT        2
`define CG_EXT_IRQ1_BIT        1
`define CG_EXT_IRQ0_BIT        0

`endif

// ===== core/clock_gate_cell.v
`timescale 1ns/1ps

// ****************************************************************
// Glitch-free clock gate
// ****************************************************************
module clock_gate_cell (
   clk,
   nrst,
   enable,
   gated_clk,
   enabled
);
   input  wire clk;
   input  wire nrst;
   input  wire enable;
   output wire gated_clk;
   output wire enabled;

   reg en_r;

   // Enable is taken on the falling edge of clk, so the AND below never chops a high phase
   always @(negedge clk or negedge nrst) begin
      if (!nrst) begin
         en_r <= 1'b0;
      end else begin
         en_r <= enable;
      end
   end

   assign gated_clk = clk & en_r;
   assign enabled   = en_r;

endmodule

// ===== core/peripheral_clock_gating.v
`timescale 1ns/1ps
`include "clock_gate_defs.vh"

module peripheral_clock_gating (
   clk,
   nrst,
   addr,
   wdata,
   wr,
   rd,
   rdata,
   timer_pair_2_3_clk,
   timer_pair_0_1_clk,
   timer_chan_a1_clk,
   timer_chan_a0_clk,
   i2c_unit_clk,
   uart_ch1_clk,
   uart_ch0_clk,
   realtime_clock_clk,
   serial_io_ch0_clk,
   ext_irq5_clk,
   ext_irq4_clk,
   ext_irq3_clk,
   ext_irq2_clk,
   ext_irq1_clk,
   ext_irq0_clk,
   gate_active
);
   input  wire                    clk;
   input  wire                    nrst;
   input  wire [`CG_ADDR_W-1:0]   addr;
   input  wire [`CG_DATA_W-1:0]   wdata;
   input  wire                    wr;
   input  wire                    rd;
   output reg  [`CG_DATA_W-1:0]   rdata;
   output wire                    timer_pair_2_3_clk;
   output wire                    timer_pair_0_1_clk;
   output wire                    timer_chan_a1_clk;
   output wire                    timer_chan_a0_clk;
   output wire                    i2c_unit_clk;
   output wire                    uart_ch1_clk;
   output wire                    uart_ch0_clk;
   output wire                    realtime_clock_clk;
   output wire                    serial_io_ch0_clk;
   output wire                    ext_irq5_clk;
   output wire                    ext_irq4_clk;
   output wire                    ext_irq3_clk;
   output wire                    ext_irq2_clk;
   output wire                    ext_irq1_clk;
   output wire                    ext_irq0_clk;
   output wire [15:0]             gate_active;

   localparam NUM_GATES = 16;

   // ****************************************************************
   // Gate registers
   // ****************************************************************
   reg  [`CG_DATA_W-1:0] timer_clock_gate_r;
   reg  [`CG_DATA_W-1:0] serial_clock_gate_r;
   reg  [`CG_DATA_W-1:0] rtc_sio_clock_gate_r;
   reg  [`CG_DATA_W-1:0] ext_irq_clock_gate_r;
   reg  [`CG_DATA_W-1:0] rdata_nxt;
   wire                  sel_timer;
   wire                  sel_serial;
   wire                  sel_rtc_sio;
   wire                  sel_ext_irq;

   assign sel_timer   = (addr == `CG_TIMER_GATE_ADDR);
   assign sel_serial  = (addr == `CG_SERIAL_GATE_ADDR);
   assign sel_rtc_sio = (addr == `CG_RTC_SIO_GATE_ADDR);
   assign sel_ext_irq = (addr == `CG_EXT_IRQ_GATE_ADDR);

   // Unnamed bits are stored too, so software reads back what it wrote
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         timer_clock_gate_r   <= `CG_REG_RESET;
         serial_clock_gate_r  <= `CG_REG_RESET;
         rtc_sio_clock_gate_r <= `CG_REG_RESET;
         ext_irq_clock_gate_r <= `CG_REG_RESET;
      end else if (wr) begin
         if (sel_timer) begin
            timer_clock_gate_r <= wdata;
         end
         if (sel_serial) begin
            serial_clock_gate_r <= wdata;
         end
         if (sel_rtc_sio) begin
            rtc_sio_clock_gate_r <= wdata;
         end
         if (sel_ext_irq) begin
            ext_irq_clock_gate_r <= wdata;
         end
      end
   end

   // ****************************************************************
   // Read port
   // ****************************************************************
   always @* begin
      rdata_nxt = `CG_READ_IDLE;
      if (rd) begin
         if (sel_timer) begin
            rdata_nxt = timer_clock_gate_r;
         end else if (sel_serial) begin
            rdata_nxt = serial_clock_gate_r;
         end else if (sel_rtc_sio) begin
            rdata_nxt = rtc_sio_clock_gate_r;
         end else if (sel_ext_irq) begin
            rdata_nxt = ext_irq_clock_gate_r;
         end else begin
            rdata_nxt = `CG_READ_IDLE;
         end
      end
   end

   // Data stand only in the cycle after the read strobe, zero otherwise
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rdata <= `CG_READ_IDLE;
      end else begin
         rdata <= rdata_nxt;
      end
   end

   // ****************************************************************
   // Gate enable map
   // ****************************************************************
   wire [NUM_GATES-1:0] gate_en;
   wire [NUM_GATES-1:0] gated;

   assign gate_en[15] = timer_clock_gate_r[`CG_TIMER_PAIR_2_3_BIT];
   assign gate_en[14] = timer_clock_gate_r[`CG_TIMER_PAIR_0_1_BIT];
   assign gate_en[13] = timer_clock_gate_r[`CG_TIMER_CHAN_A1_BIT];
   assign gate_en[12] = timer_clock_gate_r[`CG_TIMER_CHAN_A0_BIT];
   assign gate_en[11] = serial_clock_gate_r[`CG_I2C_UNIT_BIT];
   assign gate_en[10] = serial_clock_gate_r[`CG_UART_CH1_BIT];
   assign gate_en[9]  = serial_clock_gate_r[`CG_UART_CH0_BIT];
   assign gate_en[8]  = rtc_sio_clock_gate_r[`CG_REALTIME_CLOCK_BIT];
   assign gate_en[7]  = rtc_sio_clock_gate_r[`CG_SERIAL_IO_CH0_BIT];
   assign gate_en[6]  = 1'b0;
   assign gate_en[5]  = ext_irq_clock_gate_r[`CG_EXT_IRQ5_BIT];
   assign gate_en[4]  = ext_irq_clock_gate_r[`CG_EXT_IRQ4_BIT];
   assign gate_en[3]  = ext_irq_clock_gate_r[`CG_EXT_IRQ3_BIT];
   assign gate_en[2]  = ext_irq_clock_gate_r[`CG_EXT_IRQ2_BIT];
   assign gate_en[1]  = ext_irq_clock_gate_r[`CG_EXT_IRQ1_BIT];
   assign gate_en[0]  = ext_irq_clock_gate_r[`CG_EXT_IRQ0_BIT];

   // ****************************************************************
   // Clock gates
   // ****************************************************************
   // Clearing a gate stops the clock from the next rising edge after the write; software must first idle the unit
   genvar g;
   generate
      for (g = 0; g < NUM_GATES; g = g + 1) begin : gate_cells
         clock_gate_cell u_gate (
            .clk       (clk),
            .nrst      (nrst),
            .enable    (gate_en[g]),
            .gated_clk (gated[g]),
            .enabled   (gate_active[g])
         );
      end
   endgenerate

   assign timer_pair_2_3_clk = gated[15];
   assign timer_pair_0_1_clk = gated[14];
   assign timer_chan_a1_clk  = gated[13];
   assign timer_chan_a0_clk  = gated[12];
   assign i2c_unit_clk       = gated[11];
   assign uart_ch1_clk       = gated[10];
   assign uart_ch0_clk       = gated[9];
   assign realtime_clock_clk = gated[8];
   assign serial_io_ch0_clk  = gated[7];
   assign ext_irq5_clk       = gated[5];
   assign ext_irq4_clk       = gated[4];
   assign ext_irq3_clk       = gated[3];
   assign ext_irq2_clk       = gated[2];
   assign ext_irq1_clk       = gated[1];
   assign ext_irq0_clk       = gated[0];

endmodule

// ===== tb/gate_checker_asserts.sv
`timescale 1ns/1ps
// ****************************************
// Register and gated clock checks
// ****************************************
module gate_checker (
   input wire        clk,
   input wire        nrst,
   input wire [15:0] addr,
   input wire [7:0]  wdata,
   input wire        wr,
   input wire        rd,
   input wire [7:0]  rdata,
   input wire [15:0] gate_active,
   input wire        timer_pair_2_3_clk,
   input wire        timer_pair_0_1_clk,
   input wire        timer_chan_a1_clk,
   input wire        timer_chan_a0_clk,
   input wire        i2c_unit_clk,
   input wire        uart_ch1_clk,
   input wire        uart_ch0_clk,
   input wire        realtime_clock_clk,
   input wire        serial_io_ch0_clk,
   input wire        ext_irq5_clk,
   input wire        ext_irq4_clk,
   input wire        ext_irq3_clk,
   input wire        ext_irq2_clk,
   input wire        ext_irq1_clk,
   input wire        ext_irq0_clk
);
   wire [14:0] gclk = {timer_pair_2_3_clk, timer_pair_0_1_clk, timer_chan_a1_clk,
      timer_chan_a0_clk, i2c_unit_clk, uart_ch1_clk, uart_ch0_clk, realtime_clock_clk,
      serial_io_ch0_clk, ext_irq5_clk, ext_irq4_clk, ext_irq3_clk, ext_irq2_clk,
      ext_irq1_clk, ext_irq0_clk};
   wire        hit = (addr[15:2] == 14'h03DD);
   reg  [7:0]  wd_r;
   always @(posedge clk) begin
      wd_r <= wdata;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   AST_RESET_CLEAR: assert property ($rose(nrst) |-> gate_active == 16'h0000 && rdata == 8'h00)
      else $error("gate state not clear after reset");
   // Write data is two edges old when the read answer stands
   AST_READ_BACK: assert property ((wr && hit) ##1 (rd && $stable(addr)) |=>
      rdata == $past(wdata, 2))
      else $error("read after write returned other data");
   AST_READ_IDLE: assert property (!$past(rd) |-> rdata == 8'h00)
      else $error("read data outside its cycle");
   AST_UNMAPPED_READ: assert property (rd && !hit |=> rdata == 8'h00)
      else $error("unmapped read returned data");
   AST_NO_STRAY: assert property (!(wr && hit) |=> $stable(gate_active))
      else $error("gate changed without a mapped write");
   AST_TIMER_MAP: assert property (wr && addr == 16'h0F74 |=>
      gate_active[15:12] == {wd_r[5:4], wd_r[1:0]}) else $error("timer gate map wrong");
   AST_SERIAL_MAP: assert property (wr && addr == 16'h0F75 |=>
      gate_active[11:9] == {wd_r[4], wd_r[1:0]}) else $error("serial gate map wrong");
   AST_RTC_MAP: assert property (wr && addr == 16'h0F76 |=>
      gate_active[8:7] == {wd_r[5], wd_r[0]}) else $error("rtc gate map wrong");
   AST_IRQ_MAP: assert property (wr && addr == 16'h0F77 |=>
      gate_active[5:0] == wd_r[5:0]) else $error("irq gate map wrong");
   AST_SPARE_ZERO: assert property (gate_active[6] == 1'b0)
      else $error("unused gate index set");
   // Sampled just before the fall, so clk is still high and the enable not yet updated
   AST_CLOCK_FOLLOWS: assert property (@(negedge clk) disable iff (!nrst)
      gclk == {gate_active[15:7], gate_active[5:0]}) else $error("gated clock mismatch");
   cover property (wr && addr == 16'h0F77);
   cover property ((rd && hit) ##1 rdata != 8'h00);
   cover property ($rose(nrst));
endmodule
bind peripheral_clock_gating gate_checker chk (.*);

// ===== tb/test_peripheral_clock_gating.sv
`timescale 1ns/1ps
// ****************************************
// Bench
// ****************************************
module test_peripheral_clock_gating;
   reg         clk = 1'b0;
   reg         nrst = 1'b0;
   reg  [15:0] addr = 16'h0000;
   reg  [7:0]  wdata = 8'h00;
   reg         wr = 1'b0;
   reg         rd = 1'b0;
   wire [7:0]  rdata;
   wire [15:0] gate_active;
   wire [14:0] gclk;
   reg  [7:0]  mdl [0:3];
   reg  [15:0] g;
   integer     mismatches = 0;
   integer     compares = 0;
   int         i;
   peripheral_clock_gating dut (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata(rdata), .gate_active(gate_active), .timer_pair_2_3_clk(gclk[14]),
      .timer_pair_0_1_clk(gclk[13]), .timer_chan_a1_clk(gclk[12]), .timer_chan_a0_clk(gclk[11]),
      .i2c_unit_clk(gclk[10]), .uart_ch1_clk(gclk[9]), .uart_ch0_clk(gclk[8]),
      .realtime_clock_clk(gclk[7]), .serial_io_ch0_clk(gclk[6]), .ext_irq5_clk(gclk[5]),
      .ext_irq4_clk(gclk[4]), .ext_irq3_clk(gclk[3]), .ext_irq2_clk(gclk[2]),
      .ext_irq1_clk(gclk[1]), .ext_irq0_clk(gclk[0]));
   initial forever #2 clk = ~clk;
   function automatic logic [15:0] gmap();
      gmap = {mdl[0][5:4], mdl[0][1:0], mdl[1][4], mdl[1][1:0], mdl[2][5], mdl[2][0],
              1'b0, mdl[3][5:0]};
   endfunction
   task check(input logic [15:0] seen, input logic [15:0] exp);
      compares = compares + 1;
      if (seen !== exp) begin
         mismatches = mismatches + 1;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task bus(input logic w, input logic r, input logic [15:0] ad, input logic [7:0] dt);
      @(posedge clk);
      wr <= w;
      rd <= r;
      addr <= ad;
      wdata <= dt;
   endtask
   task rd_reg(input logic [15:0] ad);
      bus(1'b0, 1'b1, ad, 8'h00);
      bus(1'b0, 1'b0, ad, 8'h00);
      #1 check({8'h00, rdata}, (ad[15:2] == 14'h03DD) ? {8'h00, mdl[ad[1:0]]} : 16'h0000);
   endtask
   task wr_rd(input logic [15:0] ad, input logic [7:0] dt);
      bus(1'b1, 1'b0, ad, dt);
      if (ad[15:2] == 14'h03DD) mdl[ad[1:0]] = dt;
      rd_reg(ad);
   endtask
   task chk_gates;
      @(posedge clk);
      #1 g = gmap();
      check(gate_active, g);
      check({1'b0, gclk}, {1'b0, g[15:7], g[5:0]});
      #2 check({1'b0, gclk}, 16'h0000);
   endtask
   // Reset holds through 8 edges so async clear is seen with the bus idle
   task rst_cycle;
      nrst <= 1'b0;
      repeat (8) @(posedge clk);
      check(gate_active, 16'h0000);
      check({8'h00, rdata}, 16'h0000);
      for (int j = 0; j < 4; j++) mdl[j] = 8'h00;
      nrst <= 1'b1;
   endtask
   task close_out;
      if (mismatches == 0 && compares > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      i = $urandom(39);
      rst_cycle;
      for (i = 0; i < 4; i++) rd_reg(16'h0F74 + i[15:0]);
      for (i = 0; i < 4; i++) wr_rd(16'h0F74 + i[15:0], 8'hFF);
      chk_gates;
      wr_rd(16'h0F73, 8'hA5);
      wr_rd(16'h0F78, 8'h00);
      chk_gates;
      // No peripheral runs behind the gates here, so random clears are legal
      repeat (60) begin
         wr_rd(16'h0F73 + 16'($urandom_range(5)), 8'($urandom));
         chk_gates;
      end
      rst_cycle;
      chk_gates;
      close_out;
   end
   // Whole run is about 285 cycles; the limit of 10000 cycles leaves ample margin
   initial begin
      #40000;
      mismatches = mismatches + 1;
      close_out;
   end
endmodule
